// ==== design/ids_defs.vh ====
`ifndef IDS_DEFS_VH
`define IDS_DEFS_VH
// ----------------------------------------
// widths and counts
// ----------------------------------------
`define IDS_W 16
`define IDS_DW 32
`define IDS_RIDX_W 4
`define IDS_SHAMT_W 4
`define IDS_DIV_CYC 5'h10
`define IDS_QUOT_IDX 4'h0
`define IDS_REM_IDX 4'h1
// ----------------------------------------
// shift operation codes
// ----------------------------------------
`define IDS_SH_ASR 2'h0
`define IDS_SH_LSR 2'h1
`define IDS_SH_SL 2'h2
`endif

// ==== design/ids_divshift.v ====
`timescale 1ns/1ps
`include "ids_defs.vh"

module ids_divshift (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_div_start,
  input wire i_div_signed,
  input wire i_div_long,
  input wire [`IDS_RIDX_W-1:0] i_divisor_idx,
  input wire [`IDS_RIDX_W-1:0] i_dividend_idx,
  input wire i_sh_start,
  input wire [1:0] i_sh_op,
  input wire [`IDS_SHAMT_W-1:0] i_sh_amt,
  input wire [`IDS_RIDX_W-1:0] i_sh_src_idx,
  input wire [`IDS_RIDX_W-1:0] i_sh_dst_idx,
  input wire [`IDS_W*16-1:0] i_wreg_flat,
  output reg o_busy,
  output reg o_div_done,
  output reg o_wr0_en,
  output reg [`IDS_RIDX_W-1:0] o_wr0_idx,
  output reg [`IDS_W-1:0] o_wr0_data,
  output reg o_wr1_en,
  output reg [`IDS_RIDX_W-1:0] o_wr1_idx,
  output reg [`IDS_W-1:0] o_wr1_data
);

  // ----------------------------------------
  // register file read
  // ----------------------------------------
  function [`IDS_W-1:0] rd_reg;
    input [`IDS_W*16-1:0] flat;
    input [`IDS_RIDX_W-1:0] idx;
    begin
      rd_reg = flat[idx*`IDS_W +: `IDS_W];
    end
  endfunction

  // ----------------------------------------
  // sign helpers
  // ----------------------------------------
  function [`IDS_W-1:0] neg16;
    input [`IDS_W-1:0] v;
    begin
      neg16 = ~v + 16'h0001;
    end
  endfunction

  function [`IDS_DW-1:0] neg32;
    input [`IDS_DW-1:0] v;
    begin
      neg32 = ~v + 32'h0000_0001;
    end
  endfunction

  // ----------------------------------------
  // divider state
  // ----------------------------------------
  // two states; the count register tells the iterations apart
  localparam ST_IDLE = 1'b0;
  localparam ST_DIV = 1'b1;

  reg state_q;
  reg state_d;
  reg [4:0] cnt_q;
  reg [4:0] cnt_d;
  reg [`IDS_DW-1:0] dvd_q;
  reg [`IDS_DW-1:0] dvd_d;
  reg [`IDS_W:0] rem_q;
  reg [`IDS_W:0] rem_d;
  reg [`IDS_W-1:0] dvs_q;
  reg [`IDS_W-1:0] dvs_d;
  reg qneg_q;
  reg qneg_d;
  reg rneg_q;
  reg rneg_d;
  // write-back next values, registered so every output leaves a flip-flop
  reg busy_d;
  reg done_d;
  reg wr0_en_d;
  reg [`IDS_RIDX_W-1:0] wr0_idx_d;
  reg [`IDS_W-1:0] wr0_data_d;
  reg wr1_en_d;
  reg [`IDS_RIDX_W-1:0] wr1_idx_d;
  reg [`IDS_W-1:0] wr1_data_d;

  // ----------------------------------------
  // operand select
  // ----------------------------------------
  wire [`IDS_W-1:0] divisor_raw = rd_reg(i_wreg_flat, i_divisor_idx);
  wire [`IDS_RIDX_W-1:0] even_idx = {i_dividend_idx[`IDS_RIDX_W-1:1], 1'b0};
  wire [`IDS_RIDX_W-1:0] odd_idx = {i_dividend_idx[`IDS_RIDX_W-1:1], 1'b1};
  wire [`IDS_W-1:0] dvd_lo = rd_reg(i_wreg_flat, even_idx);
  wire [`IDS_W-1:0] dvd_hi_pair = rd_reg(i_wreg_flat, odd_idx);
  wire [`IDS_W-1:0] dvd_single = rd_reg(i_wreg_flat, i_dividend_idx);
  // a 16-bit dividend is widened to 32 so both sizes share one datapath
  wire [`IDS_DW-1:0] dvd_raw = i_div_long ? {dvd_hi_pair, dvd_lo} :
    {{`IDS_W{i_div_signed & dvd_single[`IDS_W-1]}}, dvd_single};

  // ----------------------------------------
  // operand magnitudes
  // ----------------------------------------
  wire dvd_neg = i_div_signed & dvd_raw[`IDS_DW-1];
  wire dvs_neg = i_div_signed & divisor_raw[`IDS_W-1];
  wire [`IDS_DW-1:0] dvd_mag = dvd_neg ? neg32(dvd_raw) : dvd_raw;
  wire [`IDS_W-1:0] dvs_mag = dvs_neg ? neg16(divisor_raw) : divisor_raw;

  // ----------------------------------------
  // restoring divide step
  // ----------------------------------------
  // magnitude upper half must be below divisor for a 16-bit quotient; otherwise the
  // low 16 quotient bits are right only while it is below twice the divisor, a limitation also seen in the target core
  wire div_last = (state_q == ST_DIV) & (cnt_q == 5'h01);
  wire div_go = i_div_start & (state_q == ST_IDLE);
  wire [`IDS_W:0] shrem = {rem_q[`IDS_W-1:0], dvd_q[`IDS_DW-1]};
  wire [`IDS_W:0] trial_s = shrem - {1'b0, dvs_q};

  // ----------------------------------------
  // divider control
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    dvd_d = dvd_q;
    rem_d = rem_q;
    dvs_d = dvs_q;
    qneg_d = qneg_q;
    rneg_d = rneg_q;
    case (state_q)
      ST_IDLE: begin
        if (i_div_start) begin
          state_d = ST_DIV;
          cnt_d = `IDS_DIV_CYC;
          dvs_d = dvs_mag;
          qneg_d = dvd_neg ^ dvs_neg;
          rneg_d = dvd_neg;
          rem_d = {1'b0, dvd_mag[`IDS_DW-1:`IDS_W]};
          dvd_d = {dvd_mag[`IDS_W-1:0], {`IDS_W{1'b0}}};
          // upper half at or above the divisor: quotient overflows, low bits kept only below twice the divisor
          if (rem_d >= {1'b0, dvs_mag}) begin
            rem_d = rem_d - {1'b0, dvs_mag};
          end
        end
      end
      ST_DIV: begin
        // one quotient bit per cycle, same count for both dividend sizes
        if (trial_s[`IDS_W]) begin
          rem_d = shrem;
          dvd_d = {dvd_q[`IDS_DW-2:0], 1'b0};
        end else begin
          rem_d = trial_s;
          dvd_d = {dvd_q[`IDS_DW-2:0], 1'b1};
        end
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // result sign fix-up
  // ----------------------------------------
  wire [`IDS_W-1:0] q_mag = dvd_d[`IDS_W-1:0];
  wire [`IDS_W-1:0] r_mag = rem_d[`IDS_W-1:0];
  wire [`IDS_W-1:0] q_fin = qneg_q ? neg16(q_mag) : q_mag;
  wire [`IDS_W-1:0] r_fin = rneg_q ? neg16(r_mag) : r_mag;

  // ----------------------------------------
  // single-cycle shifter
  // ----------------------------------------
  wire [`IDS_W-1:0] sh_src = rd_reg(i_wreg_flat, i_sh_src_idx);
  // log shifter: stages of 1, 2, 4 and 8 places cover every count up to 15
  wire [`IDS_W-1:0] stg_r [0:`IDS_SHAMT_W];
  wire [`IDS_W-1:0] stg_l [0:`IDS_SHAMT_W];
  // only the arithmetic form refills the top with the sign
  wire fill_r = (i_sh_op == `IDS_SH_ASR) & sh_src[`IDS_W-1];
  assign stg_r[0] = sh_src;
  assign stg_l[0] = sh_src;
  genvar gs;
  generate
    for (gs = 0; gs < `IDS_SHAMT_W; gs = gs + 1) begin : g_stage
      assign stg_r[gs+1] = i_sh_amt[gs] ? {{(1 << gs){fill_r}}, stg_r[gs][`IDS_W-1:(1 << gs)]} : stg_r[gs];
      assign stg_l[gs+1] = i_sh_amt[gs] ? {stg_l[gs][`IDS_W-1-(1 << gs):0], {(1 << gs){1'b0}}} : stg_l[gs];
    end
  endgenerate

  // ----------------------------------------
  // shift select
  // ----------------------------------------
  reg [`IDS_W-1:0] sh_res;
  always @* begin
    case (i_sh_op)
      `IDS_SH_ASR: sh_res = stg_r[`IDS_SHAMT_W];
      `IDS_SH_LSR: sh_res = stg_r[`IDS_SHAMT_W];
      `IDS_SH_SL: sh_res = stg_l[`IDS_SHAMT_W];
      default: sh_res = sh_src;
    endcase
  end

  // ----------------------------------------
  // request acceptance
  // ----------------------------------------
  // a shift beside a divide start is refused; the divide keeps the ports
  wire sh_go = i_sh_start & (state_q == ST_IDLE) & ~div_go;

  // ----------------------------------------
  // divider state registers
  // ----------------------------------------
  // datapath flip-flops; only the output bank is seen outside
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      dvd_q <= 32'h0000_0000;
      rem_q <= 17'h0_0000;
      dvs_q <= 16'h0000;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dvd_q <= dvd_d;
      rem_q <= rem_d;
      dvs_q <= dvs_d;
      qneg_q <= qneg_d;
      rneg_q <= rneg_d;
    end
  end

  // ----------------------------------------
  // write-back next values
  // ----------------------------------------
  // divide results take priority over a shift for port 0
  always @* begin
    busy_d = (state_d == ST_DIV);
    done_d = 1'b0;
    wr0_en_d = 1'b0;
    wr0_idx_d = o_wr0_idx;
    wr0_data_d = o_wr0_data;
    wr1_en_d = 1'b0;
    wr1_idx_d = o_wr1_idx;
    wr1_data_d = o_wr1_data;
    if (div_last) begin
      done_d = 1'b1;
      wr0_en_d = 1'b1;
      wr0_idx_d = `IDS_QUOT_IDX;
      wr0_data_d = q_fin;
      wr1_en_d = 1'b1;
      wr1_idx_d = `IDS_REM_IDX;
      wr1_data_d = r_fin;
    end else if (sh_go) begin
      wr0_en_d = 1'b1;
      wr0_idx_d = i_sh_dst_idx;
      wr0_data_d = sh_res;
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // idx and data hold between writes so a watcher sees the last result
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy <= 1'b0;
      o_div_done <= 1'b0;
      o_wr0_en <= 1'b0;
      o_wr0_idx <= 4'h0;
      o_wr0_data <= 16'h0000;
      o_wr1_en <= 1'b0;
      o_wr1_idx <= 4'h0;
      o_wr1_data <= 16'h0000;
    end else begin
      o_busy <= busy_d;
      o_div_done <= done_d;
      o_wr0_en <= wr0_en_d;
      o_wr0_idx <= wr0_idx_d;
      o_wr0_data <= wr0_data_d;
      o_wr1_en <= wr1_en_d;
      o_wr1_idx <= wr1_idx_d;
      o_wr1_data <= wr1_data_d;
    end
  end

endmodule

// ==== verification/ids_regfile.sv ====
`timescale 1ns/1ps
// ----
// working registers, written through the block's two write ports and a testbench load port
// ----
module ids_regfile (
  input wire i_clk,
  input wire i_wr0_en,
  input wire [3:0] i_wr0_idx,
  input wire [15:0] i_wr0_data,
  input wire i_wr1_en,
  input wire [3:0] i_wr1_idx,
  input wire [15:0] i_wr1_data,
  input wire i_ld_en,
  input wire [3:0] i_ld_idx,
  input wire [15:0] i_ld_data,
  output logic [255:0] o_flat
);
  initial o_flat = '0;
  always @(posedge i_clk) begin
    if (i_ld_en) o_flat[i_ld_idx*16 +: 16] <= i_ld_data;
    if (i_wr0_en) o_flat[i_wr0_idx*16 +: 16] <= i_wr0_data;
    if (i_wr1_en) o_flat[i_wr1_idx*16 +: 16] <= i_wr1_data;
  end
endmodule

// ==== verification/ids_divshift_assertions.sv ====
`timescale 1ns/1ps
module ids_divshift_assertions (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_div_start,
  input wire i_sh_start,
  input wire [1:0] i_sh_op,
  input wire [3:0] i_sh_amt,
  input wire [3:0] i_sh_src_idx,
  input wire [3:0] i_sh_dst_idx,
  input wire [255:0] i_wreg_flat,
  input wire o_busy,
  input wire o_div_done,
  input wire o_wr0_en,
  input wire [3:0] o_wr0_idx,
  input wire [15:0] o_wr0_data,
  input wire o_wr1_en,
  input wire [3:0] o_wr1_idx
);
  // ----
  // checks
  // ----
  wire [15:0] src = i_wreg_flat[i_sh_src_idx*16 +: 16];
  // signed cast keeps the shift arithmetic
  wire signed [15:0] arith_right_shift_instr = $signed(src) >>> i_sh_amt;
  wire [15:0] logic_right_shift_instr = src >> i_sh_amt;
  wire [15:0] sl = src << i_sh_amt;
  wire sh_ok = i_sh_start && !o_busy && !i_div_start;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_sh_lat; sh_ok |=> o_wr0_en && o_wr0_idx == $past(i_sh_dst_idx); endproperty
  a_sh_lat: assert property (p_sh_lat) else $error("shift write late");
  property p_asr; sh_ok && i_sh_op == 2'h0 |=> o_wr0_data == $past(arith_right_shift_instr); endproperty
  a_asr: assert property (p_asr) else $error("asr wrong");
  property p_lsr; sh_ok && i_sh_op == 2'h1 |=> o_wr0_data == $past(logic_right_shift_instr); endproperty
  a_lsr: assert property (p_lsr) else $error("lsr wrong");
  property p_sl; sh_ok && i_sh_op == 2'h2 |=> o_wr0_data == $past(sl); endproperty
  a_sl: assert property (p_sl) else $error("sl wrong");
  property p_div_len; i_div_start && !o_busy |=> o_busy[*8] ##1 o_busy[*8] ##1 (o_div_done && !o_busy); endproperty
  a_div_len: assert property (p_div_len) else $error("divide length");
  property p_div_dst; o_div_done |-> o_wr0_en && o_wr1_en && o_wr0_idx == 4'h0 && o_wr1_idx == 4'h1; endproperty
  a_div_dst: assert property (p_div_dst) else $error("divide dest");
  property p_busy_src; $rose(o_busy) |-> $past(i_div_start); endproperty
  a_busy_src: assert property (p_busy_src) else $error("busy no start");
  property p_wr1_only; o_wr1_en |-> o_div_done; endproperty
  a_wr1_only: assert property (p_wr1_only) else $error("stray wr1");
  c_div: cover property (o_div_done);
  c_sh15: cover property (sh_ok && i_sh_amt == 4'hf);
  c_sl: cover property (sh_ok && i_sh_op == 2'h2);
endmodule

bind ids_divshift ids_divshift_assertions u_chk (.*);

// ==== verification/ids_divshift_tb.sv ====
`timescale 1ns/1ps
module ids_divshift_tb;
  logic i_clk = 0, i_arst_n = 0, i_div_start = 0, i_div_signed = 0, i_div_long = 0, i_sh_start = 0, ld_en = 0;
  logic [1:0] i_sh_op = 0;
  logic [3:0] i_divisor_idx = 0, i_dividend_idx = 0, i_sh_amt = 0, i_sh_src_idx = 0, i_sh_dst_idx = 0, ld_idx = 0;
  logic [15:0] ld_data = 0;
  wire [255:0] i_wreg_flat;
  wire o_busy, o_div_done, o_wr0_en, o_wr1_en;
  wire [3:0] o_wr0_idx, o_wr1_idx;
  wire [15:0] o_wr0_data, o_wr1_data;
  int err_total = 0, check_count = 0, cyc = 0;
  always #4 i_clk = ~i_clk;
  ids_divshift dut (.*);
  ids_regfile u_rf (.i_clk(i_clk), .i_wr0_en(o_wr0_en), .i_wr0_idx(o_wr0_idx), .i_wr0_data(o_wr0_data),
    .i_wr1_en(o_wr1_en), .i_wr1_idx(o_wr1_idx), .i_wr1_data(o_wr1_data), .i_ld_en(ld_en),
    .i_ld_idx(ld_idx), .i_ld_data(ld_data), .o_flat(i_wreg_flat));
  // ----
  // helpers
  // ----
  task chk(input [15:0] got, input [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // caller lowers ld_en, so loads may run back to back
  task ld(input [3:0] k, input [15:0] v);
    ld_idx = k;
    ld_data = v;
    ld_en = 1;
    @(posedge i_clk) #1;
  endtask
  task shift(input [1:0] op, input [3:0] n, input [15:0] exp);
    i_sh_op = op;
    i_sh_amt = n;
    i_sh_src_idx = 4'h5;
    i_sh_dst_idx = 4'h9;
    i_sh_start = 1;
    @(posedge i_clk) #1;
    chk(o_wr0_en, 1);
    chk(o_wr0_idx, 4'h9);
    chk(o_wr0_data, exp);
  endtask
  task div(input sg, input lg, input [3:0] dv, input [3:0] dd, input [15:0] q, input [15:0] r);
    int n;
    n = 0;
    i_div_signed = sg;
    i_div_long = lg;
    i_divisor_idx = dv;
    i_dividend_idx = dd;
    i_div_start = 1;
    @(posedge i_clk) #1 i_div_start = 0;
    chk(o_busy, 1);
    do begin
      @(posedge i_clk) #1 n++;
    end while (!o_div_done && n < 20);
    chk(n, 16);
    chk(o_busy, 0);
    chk(o_wr0_data, q);
    chk(o_wr1_data, r);
    @(posedge i_clk) #1;
    chk(i_wreg_flat[15:0], q);
    chk(i_wreg_flat[31:16], r);
  endtask
  // ----
  // scenarios
  // ----
  task sh_scn;
    logic [15:0] s;
    logic signed [15:0] a;
    s = 16'h8a5c;
    ld(4'h5, s);
    ld_en = 0;
    for (int n = 0; n < 16; n += 5) begin
      a = $signed(s) >>> n;
      shift(2'h0, n[3:0], a);
      shift(2'h1, n[3:0], s >> n);
      shift(2'h2, n[3:0], s << n);
    end
    shift(2'h3, 4'h7, s);
    i_sh_start = 0;
  endtask
  task div_scn;
    ld(4'h2, 16'h03e8);
    ld(4'h3, 16'h0007);
    ld(4'h4, 16'hfc18);
    ld(4'h6, 16'h0005);
    ld(4'h7, 16'h0003);
    ld(4'hb, 16'hfff9);
    ld(4'hc, 16'hfffb);
    ld(4'hd, 16'hfffc);
    ld_en = 0;
    div(0, 0, 4'h3, 4'h2, 16'h008e, 16'h0006);
    div(1, 0, 4'hb, 4'h4, 16'h008e, 16'hfffa);
    div(1, 0, 4'h3, 4'h4, 16'hff72, 16'hfffa);
    div(0, 1, 4'h3, 4'h7, 16'h6db7, 16'h0004);
    div(1, 1, 4'h3, 4'hc, 16'h9249, 16'hfffc);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_arst_n = 1;
    sh_scn;
    div_scn;
    complete_run;
  end
endmodule
